// ---- hw/sfrmd_consts.vh ----
/*
  Constants for the special-function-register bank: address space bounds,
  direct register offsets, reset values and write masks.
  Assumes inclusion by bare name from the bank module.
*/
`ifndef SFRMD_CONSTS_VH
`define SFRMD_CONSTS_VH

// address spaces
`define SFRMD_DIR_BASE 8'h80
`define SFRMD_XSFR_BASE 16'hFC00

// direct register offsets
`define SFRMD_STACK_POINTER 8'h81
`define SFRMD_DATA_POINTER_LOW_0 8'h82
`define SFRMD_DATA_POINTER_HIGH_0 8'h83
`define SFRMD_DATA_POINTER_LOW_1 8'h84
`define SFRMD_DATA_POINTER_HIGH_1 8'h85
`define SFRMD_WATCHDOG_RELOAD 8'h86
`define SFRMD_POWER_CONTROL 8'h87
`define SFRMD_TIMER_COUNTER_CONTROL 8'h88
`define SFRMD_TIMER_MODE_CONTROL 8'h89
`define SFRMD_TIMER0_LOW_BYTE 8'h8A
`define SFRMD_TIMER1_LOW_BYTE 8'h8B
`define SFRMD_TIMER0_HIGH_BYTE 8'h8C
`define SFRMD_TIMER1_HIGH_BYTE 8'h8D
`define SFRMD_WAIT_STATE_CONTROL 8'h8E
`define SFRMD_MASTER_CLOCK_CONTROL 8'h8F
`define SFRMD_USER_PORT_DATA_LOW 8'h90
`define SFRMD_USER_PORT_DIRECTION_LOW 8'h91
`define SFRMD_POINTER_SELECT 8'h92
`define SFRMD_FLASH_ERASE 8'h94
`define SFRMD_SERIAL0_CONTROL 8'h98
`define SFRMD_SERIAL0_BUFFER 8'h99
`define SFRMD_INTERRUPT_ENABLE_2 8'h9A
`define SFRMD_SERIAL1_CONTROL 8'h9B
`define SFRMD_SERIAL1_BUFFER 8'h9C
`define SFRMD_SERIAL1_RELOAD_LOW 8'h9D
`define SFRMD_USER_PORT_DATA_HIGH 8'hA0
`define SFRMD_USER_PORT_DIRECTION_HIGH 8'hA1
`define SFRMD_INTERRUPT_ENABLE_0 8'hA8
`define SFRMD_INTERRUPT_PRIORITY_0 8'hA9
`define SFRMD_SERIAL0_RELOAD_LOW 8'hAA
`define SFRMD_FLASH_CONTROL 8'hB2
`define SFRMD_FLASH_PAGE_ADDRESS 8'hB7
`define SFRMD_INTERRUPT_ENABLE_1 8'hB8
`define SFRMD_INTERRUPT_PRIORITY_1 8'hB9
`define SFRMD_SERIAL0_RELOAD_HIGH 8'hBA
`define SFRMD_SERIAL1_RELOAD_HIGH 8'hBB
`define SFRMD_INTERRUPT_REQUEST_CONTROL 8'hC0
`define SFRMD_TIMER2_CONTROL 8'hC8
`define SFRMD_PROGRAM_STATUS_WORD 8'hD0
`define SFRMD_KEYPAD_COLUMN 8'hD1
`define SFRMD_KEYPAD_ROW 8'hD2
`define SFRMD_KEYPAD_SCAN_TIME 8'hD3
`define SFRMD_KEYPAD_CONTROL_STATUS 8'hD4
`define SFRMD_KEYPAD_SIZE 8'hD5
`define SFRMD_KEYPAD_ORDER_LOW 8'hD6
`define SFRMD_KEYPAD_ORDER_HIGH 8'hD7
`define SFRMD_BAUD_RATE_CONTROL 8'hD8
`define SFRMD_ACCUMULATOR 8'hE0

// reset values; every register not listed resets to zero
`define SFRMD_RST_ZERO 8'h00
`define SFRMD_RST_STACK_POINTER 8'h07
`define SFRMD_RST_WAIT_STATE_CONTROL 8'h01
`define SFRMD_RST_MASTER_CLOCK_CONTROL 8'h0A
`define SFRMD_RST_USER_PORT_DATA_LOW 8'hFF
`define SFRMD_RST_USER_PORT_DIRECTION_LOW 8'hFF
`define SFRMD_RST_USER_PORT_DIRECTION_HIGH 8'h01
`define SFRMD_RST_SERIAL0_RELOAD_LOW 8'hD9
`define SFRMD_RST_SERIAL0_RELOAD_HIGH 8'h03
`define SFRMD_RST_SERIAL1_RELOAD_HIGH 8'h03
`define SFRMD_RST_KEYPAD_COLUMN 8'h1F
`define SFRMD_RST_KEYPAD_ROW 8'h3F

// write masks and read value of holes
`define SFRMD_WMASK_FULL 8'hFF
`define SFRMD_WMASK_BAUD_RATE_CONTROL 8'h80
`define SFRMD_HOLE_READ 8'h00
`define SFRMD_XSFR_READ 8'h00

`endif

// ---- hw/sfrmd_decoder.v ----
/*
  Special-function-register bank and decoder: holds the direct-space
  registers of the core and decodes the peripheral window at the top of
  external data space.
  Assumes the core presents address, write strobe and data synchronous to
  ref_clk_in and samples read data in the same cycle.
*/
`timescale 1ns/1ps
`include "sfrmd_consts.vh"

module sfrmd_decoder (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // direct register space from the core
  input wire [7:0] dir_addr_in,
  input wire dir_wr_in,
  input wire [7:0] dir_wdata_in,
  output reg [7:0] dir_rdata_out,
  output reg dir_sfr_sel_out,
  output reg dir_hit_out,
  // external data space from the core
  input wire [15:0] xdata_addr_in,
  output reg xdata_sfr_sel_out,
  output reg [7:0] xdata_rdata_out,
  // image of every direct register, slot n holds address 0x80+n
  output wire [1023:0] reg_image_out
);

  ////////////////////////////////////////////////////////////////////////
  // decode functions

  // true for each implemented direct offset
  function sfrmd_impl;
    input [7:0] addr;
    begin
      case (addr)
        `SFRMD_STACK_POINTER,
        `SFRMD_DATA_POINTER_LOW_0,
        `SFRMD_DATA_POINTER_HIGH_0,
        `SFRMD_DATA_POINTER_LOW_1,
        `SFRMD_DATA_POINTER_HIGH_1,
        `SFRMD_WATCHDOG_RELOAD,
        `SFRMD_POWER_CONTROL,
        `SFRMD_TIMER_COUNTER_CONTROL,
        `SFRMD_TIMER_MODE_CONTROL,
        `SFRMD_TIMER0_LOW_BYTE,
        `SFRMD_TIMER1_LOW_BYTE,
        `SFRMD_TIMER0_HIGH_BYTE,
        `SFRMD_TIMER1_HIGH_BYTE,
        `SFRMD_WAIT_STATE_CONTROL,
        `SFRMD_MASTER_CLOCK_CONTROL,
        `SFRMD_USER_PORT_DATA_LOW,
        `SFRMD_USER_PORT_DIRECTION_LOW,
        `SFRMD_POINTER_SELECT,
        `SFRMD_FLASH_ERASE,
        `SFRMD_SERIAL0_CONTROL,
        `SFRMD_SERIAL0_BUFFER,
        `SFRMD_INTERRUPT_ENABLE_2,
        `SFRMD_SERIAL1_CONTROL,
        `SFRMD_SERIAL1_BUFFER,
        `SFRMD_SERIAL1_RELOAD_LOW,
        `SFRMD_USER_PORT_DATA_HIGH,
        `SFRMD_USER_PORT_DIRECTION_HIGH,
        `SFRMD_INTERRUPT_ENABLE_0,
        `SFRMD_INTERRUPT_PRIORITY_0,
        `SFRMD_SERIAL0_RELOAD_LOW,
        `SFRMD_FLASH_CONTROL,
        `SFRMD_FLASH_PAGE_ADDRESS,
        `SFRMD_INTERRUPT_ENABLE_1,
        `SFRMD_INTERRUPT_PRIORITY_1,
        `SFRMD_SERIAL0_RELOAD_HIGH,
        `SFRMD_SERIAL1_RELOAD_HIGH,
        `SFRMD_INTERRUPT_REQUEST_CONTROL,
        `SFRMD_TIMER2_CONTROL,
        `SFRMD_PROGRAM_STATUS_WORD,
        `SFRMD_KEYPAD_COLUMN,
        `SFRMD_KEYPAD_ROW,
        `SFRMD_KEYPAD_SCAN_TIME,
        `SFRMD_KEYPAD_CONTROL_STATUS,
        `SFRMD_KEYPAD_SIZE,
        `SFRMD_KEYPAD_ORDER_LOW,
        `SFRMD_KEYPAD_ORDER_HIGH,
        `SFRMD_BAUD_RATE_CONTROL,
        `SFRMD_ACCUMULATOR: sfrmd_impl = 1'b1;
        default: sfrmd_impl = 1'b0;
      endcase
    end
  endfunction

  // reset value per offset
  function [7:0] sfrmd_rst;
    input [7:0] addr;
    begin
      case (addr)
        `SFRMD_STACK_POINTER: sfrmd_rst = `SFRMD_RST_STACK_POINTER;
        `SFRMD_WAIT_STATE_CONTROL: sfrmd_rst = `SFRMD_RST_WAIT_STATE_CONTROL;
        `SFRMD_MASTER_CLOCK_CONTROL: sfrmd_rst = `SFRMD_RST_MASTER_CLOCK_CONTROL;
        `SFRMD_USER_PORT_DATA_LOW: sfrmd_rst = `SFRMD_RST_USER_PORT_DATA_LOW;
        `SFRMD_USER_PORT_DIRECTION_LOW: sfrmd_rst = `SFRMD_RST_USER_PORT_DIRECTION_LOW;
        `SFRMD_USER_PORT_DIRECTION_HIGH: sfrmd_rst = `SFRMD_RST_USER_PORT_DIRECTION_HIGH;
        `SFRMD_SERIAL0_RELOAD_LOW: sfrmd_rst = `SFRMD_RST_SERIAL0_RELOAD_LOW;
        `SFRMD_SERIAL0_RELOAD_HIGH: sfrmd_rst = `SFRMD_RST_SERIAL0_RELOAD_HIGH;
        `SFRMD_SERIAL1_RELOAD_HIGH: sfrmd_rst = `SFRMD_RST_SERIAL1_RELOAD_HIGH;
        `SFRMD_KEYPAD_COLUMN: sfrmd_rst = `SFRMD_RST_KEYPAD_COLUMN;
        `SFRMD_KEYPAD_ROW: sfrmd_rst = `SFRMD_RST_KEYPAD_ROW;
        `SFRMD_DATA_POINTER_LOW_0,
        `SFRMD_DATA_POINTER_HIGH_0,
        `SFRMD_DATA_POINTER_LOW_1,
        `SFRMD_DATA_POINTER_HIGH_1,
        `SFRMD_WATCHDOG_RELOAD,
        `SFRMD_POWER_CONTROL,
        `SFRMD_TIMER_COUNTER_CONTROL,
        `SFRMD_TIMER_MODE_CONTROL,
        `SFRMD_TIMER0_LOW_BYTE,
        `SFRMD_TIMER1_LOW_BYTE,
        `SFRMD_TIMER0_HIGH_BYTE,
        `SFRMD_TIMER1_HIGH_BYTE,
        `SFRMD_POINTER_SELECT,
        `SFRMD_FLASH_ERASE,
        `SFRMD_SERIAL0_CONTROL,
        `SFRMD_SERIAL0_BUFFER,
        `SFRMD_INTERRUPT_ENABLE_2,
        `SFRMD_SERIAL1_CONTROL,
        `SFRMD_SERIAL1_BUFFER,
        `SFRMD_SERIAL1_RELOAD_LOW,
        `SFRMD_USER_PORT_DATA_HIGH,
        `SFRMD_INTERRUPT_ENABLE_0,
        `SFRMD_INTERRUPT_PRIORITY_0,
        `SFRMD_FLASH_CONTROL,
        `SFRMD_FLASH_PAGE_ADDRESS,
        `SFRMD_INTERRUPT_ENABLE_1,
        `SFRMD_INTERRUPT_PRIORITY_1,
        `SFRMD_INTERRUPT_REQUEST_CONTROL,
        `SFRMD_TIMER2_CONTROL,
        `SFRMD_PROGRAM_STATUS_WORD,
        `SFRMD_KEYPAD_SCAN_TIME,
        `SFRMD_KEYPAD_CONTROL_STATUS,
        `SFRMD_KEYPAD_SIZE,
        `SFRMD_KEYPAD_ORDER_LOW,
        `SFRMD_KEYPAD_ORDER_HIGH,
        `SFRMD_BAUD_RATE_CONTROL,
        `SFRMD_ACCUMULATOR: sfrmd_rst = `SFRMD_RST_ZERO;
        default: sfrmd_rst = `SFRMD_RST_ZERO;
      endcase
    end
  endfunction

  // bits that a write may change
  function [7:0] sfrmd_wmask;
    input [7:0] addr;
    begin
      if (addr == `SFRMD_BAUD_RATE_CONTROL) begin
        sfrmd_wmask = `SFRMD_WMASK_BAUD_RATE_CONTROL;
      end else begin
        sfrmd_wmask = `SFRMD_WMASK_FULL;
      end
    end
  endfunction

  // lowest image bit of a direct offset
  function [9:0] sfrmd_lsb;
    input [7:0] addr;
    begin
      sfrmd_lsb = {addr[6:0], 3'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address decode

  wire dir_space;
  wire dir_impl;
  wire [6:0] dir_slot;

  // high half of direct space is register space, low half is ram
  assign dir_space = dir_addr_in[7];
  assign dir_impl = dir_space & sfrmd_impl(dir_addr_in);
  assign dir_slot = dir_addr_in[6:0];

  ////////////////////////////////////////////////////////////////////////
  // register flops, one per implemented offset

  genvar gi;
  generate
    for (gi = 0; gi < 128; gi = gi + 1) begin : g_slot
      localparam [31:0] ADDR_FULL = `SFRMD_DIR_BASE + gi;
      localparam [7:0] ADDR = ADDR_FULL[7:0];
      if (sfrmd_impl(ADDR)) begin : g_reg
        reg [7:0] value;
        wire hit;
        wire [7:0] next_value;
        // holes never match, so writes to them touch no flop
        assign hit = dir_wr_in & dir_space & (dir_slot == ADDR[6:0]);
        // masked bits stay at reset so unused bits read back defaults
        assign next_value = hit ? ((dir_wdata_in & sfrmd_wmask(ADDR)) |
                                   (sfrmd_rst(ADDR) & ~sfrmd_wmask(ADDR))) : value;
        // loads every edge; holding is a mux, not a clock enable
        always @(posedge ref_clk_in or posedge reset_in) begin
          if (reset_in) begin
            value <= sfrmd_rst(ADDR);
          end else begin
            value <= next_value;
          end
        end
        assign reg_image_out[8*gi +: 8] = value;
      end else begin : g_hole
        assign reg_image_out[8*gi +: 8] = `SFRMD_HOLE_READ;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read paths

  // named views of the image, one per implemented register
  wire [7:0] stack_pointer;
  wire [7:0] data_pointer_low_0;
  wire [7:0] data_pointer_high_0;
  wire [7:0] data_pointer_low_1;
  wire [7:0] data_pointer_high_1;
  wire [7:0] watchdog_reload;
  wire [7:0] power_control;
  wire [7:0] timer_counter_control;
  wire [7:0] timer_mode_control;
  wire [7:0] timer0_low_byte;
  wire [7:0] timer1_low_byte;
  wire [7:0] timer0_high_byte;
  wire [7:0] timer1_high_byte;
  wire [7:0] wait_state_control;
  wire [7:0] master_clock_control;
  wire [7:0] user_port_data_low;
  wire [7:0] user_port_direction_low;
  wire [7:0] pointer_select;
  wire [7:0] flash_erase;
  wire [7:0] serial0_control;
  wire [7:0] serial0_buffer;
  wire [7:0] interrupt_enable_2;
  wire [7:0] serial1_control;
  wire [7:0] serial1_buffer;
  wire [7:0] serial1_reload_low;
  wire [7:0] user_port_data_high;
  wire [7:0] user_port_direction_high;
  wire [7:0] interrupt_enable_0;
  wire [7:0] interrupt_priority_0;
  wire [7:0] serial0_reload_low;
  wire [7:0] flash_control;
  wire [7:0] flash_page_address;
  wire [7:0] interrupt_enable_1;
  wire [7:0] interrupt_priority_1;
  wire [7:0] serial0_reload_high;
  wire [7:0] serial1_reload_high;
  wire [7:0] interrupt_request_control;
  wire [7:0] timer2_control;
  wire [7:0] program_status_word;
  wire [7:0] keypad_column;
  wire [7:0] keypad_row;
  wire [7:0] keypad_scan_time;
  wire [7:0] keypad_control_status;
  wire [7:0] keypad_size;
  wire [7:0] keypad_order_low;
  wire [7:0] keypad_order_high;
  wire [7:0] baud_rate_control;
  wire [7:0] accumulator;

  // each view is a fixed slice of the flop image
  assign stack_pointer = reg_image_out[sfrmd_lsb(`SFRMD_STACK_POINTER) +: 8];
  assign data_pointer_low_0 = reg_image_out[sfrmd_lsb(`SFRMD_DATA_POINTER_LOW_0) +: 8];
  assign data_pointer_high_0 = reg_image_out[sfrmd_lsb(`SFRMD_DATA_POINTER_HIGH_0) +: 8];
  assign data_pointer_low_1 = reg_image_out[sfrmd_lsb(`SFRMD_DATA_POINTER_LOW_1) +: 8];
  assign data_pointer_high_1 = reg_image_out[sfrmd_lsb(`SFRMD_DATA_POINTER_HIGH_1) +: 8];
  assign watchdog_reload = reg_image_out[sfrmd_lsb(`SFRMD_WATCHDOG_RELOAD) +: 8];
  assign power_control = reg_image_out[sfrmd_lsb(`SFRMD_POWER_CONTROL) +: 8];
  assign timer_counter_control = reg_image_out[sfrmd_lsb(`SFRMD_TIMER_COUNTER_CONTROL) +: 8];
  assign timer_mode_control = reg_image_out[sfrmd_lsb(`SFRMD_TIMER_MODE_CONTROL) +: 8];
  assign timer0_low_byte = reg_image_out[sfrmd_lsb(`SFRMD_TIMER0_LOW_BYTE) +: 8];
  assign timer1_low_byte = reg_image_out[sfrmd_lsb(`SFRMD_TIMER1_LOW_BYTE) +: 8];
  assign timer0_high_byte = reg_image_out[sfrmd_lsb(`SFRMD_TIMER0_HIGH_BYTE) +: 8];
  assign timer1_high_byte = reg_image_out[sfrmd_lsb(`SFRMD_TIMER1_HIGH_BYTE) +: 8];
  assign wait_state_control = reg_image_out[sfrmd_lsb(`SFRMD_WAIT_STATE_CONTROL) +: 8];
  assign master_clock_control = reg_image_out[sfrmd_lsb(`SFRMD_MASTER_CLOCK_CONTROL) +: 8];
  assign user_port_data_low = reg_image_out[sfrmd_lsb(`SFRMD_USER_PORT_DATA_LOW) +: 8];
  assign user_port_direction_low = reg_image_out[sfrmd_lsb(`SFRMD_USER_PORT_DIRECTION_LOW) +: 8];
  assign pointer_select = reg_image_out[sfrmd_lsb(`SFRMD_POINTER_SELECT) +: 8];
  assign flash_erase = reg_image_out[sfrmd_lsb(`SFRMD_FLASH_ERASE) +: 8];
  assign serial0_control = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL0_CONTROL) +: 8];
  assign serial0_buffer = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL0_BUFFER) +: 8];
  assign interrupt_enable_2 = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_ENABLE_2) +: 8];
  assign serial1_control = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL1_CONTROL) +: 8];
  assign serial1_buffer = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL1_BUFFER) +: 8];
  assign serial1_reload_low = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL1_RELOAD_LOW) +: 8];
  assign user_port_data_high = reg_image_out[sfrmd_lsb(`SFRMD_USER_PORT_DATA_HIGH) +: 8];
  assign user_port_direction_high = reg_image_out[sfrmd_lsb(`SFRMD_USER_PORT_DIRECTION_HIGH) +: 8];
  assign interrupt_enable_0 = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_ENABLE_0) +: 8];
  assign interrupt_priority_0 = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_PRIORITY_0) +: 8];
  assign serial0_reload_low = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL0_RELOAD_LOW) +: 8];
  assign flash_control = reg_image_out[sfrmd_lsb(`SFRMD_FLASH_CONTROL) +: 8];
  assign flash_page_address = reg_image_out[sfrmd_lsb(`SFRMD_FLASH_PAGE_ADDRESS) +: 8];
  assign interrupt_enable_1 = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_ENABLE_1) +: 8];
  assign interrupt_priority_1 = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_PRIORITY_1) +: 8];
  assign serial0_reload_high = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL0_RELOAD_HIGH) +: 8];
  assign serial1_reload_high = reg_image_out[sfrmd_lsb(`SFRMD_SERIAL1_RELOAD_HIGH) +: 8];
  assign interrupt_request_control = reg_image_out[sfrmd_lsb(`SFRMD_INTERRUPT_REQUEST_CONTROL) +: 8];
  assign timer2_control = reg_image_out[sfrmd_lsb(`SFRMD_TIMER2_CONTROL) +: 8];
  assign program_status_word = reg_image_out[sfrmd_lsb(`SFRMD_PROGRAM_STATUS_WORD) +: 8];
  assign keypad_column = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_COLUMN) +: 8];
  assign keypad_row = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_ROW) +: 8];
  assign keypad_scan_time = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_SCAN_TIME) +: 8];
  assign keypad_control_status = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_CONTROL_STATUS) +: 8];
  assign keypad_size = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_SIZE) +: 8];
  assign keypad_order_low = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_ORDER_LOW) +: 8];
  assign keypad_order_high = reg_image_out[sfrmd_lsb(`SFRMD_KEYPAD_ORDER_HIGH) +: 8];
  assign baud_rate_control = reg_image_out[sfrmd_lsb(`SFRMD_BAUD_RATE_CONTROL) +: 8];
  assign accumulator = reg_image_out[sfrmd_lsb(`SFRMD_ACCUMULATOR) +: 8];

  // combinational so the core sees data in the address cycle;
  // one arm per register keeps the mux to the implemented set only
  always @* begin
    dir_sfr_sel_out = dir_space;
    dir_hit_out = dir_impl;
    case (dir_addr_in)
      `SFRMD_STACK_POINTER: dir_rdata_out = stack_pointer;
      `SFRMD_DATA_POINTER_LOW_0: dir_rdata_out = data_pointer_low_0;
      `SFRMD_DATA_POINTER_HIGH_0: dir_rdata_out = data_pointer_high_0;
      `SFRMD_DATA_POINTER_LOW_1: dir_rdata_out = data_pointer_low_1;
      `SFRMD_DATA_POINTER_HIGH_1: dir_rdata_out = data_pointer_high_1;
      `SFRMD_WATCHDOG_RELOAD: dir_rdata_out = watchdog_reload;
      `SFRMD_POWER_CONTROL: dir_rdata_out = power_control;
      `SFRMD_TIMER_COUNTER_CONTROL: dir_rdata_out = timer_counter_control;
      `SFRMD_TIMER_MODE_CONTROL: dir_rdata_out = timer_mode_control;
      `SFRMD_TIMER0_LOW_BYTE: dir_rdata_out = timer0_low_byte;
      `SFRMD_TIMER1_LOW_BYTE: dir_rdata_out = timer1_low_byte;
      `SFRMD_TIMER0_HIGH_BYTE: dir_rdata_out = timer0_high_byte;
      `SFRMD_TIMER1_HIGH_BYTE: dir_rdata_out = timer1_high_byte;
      `SFRMD_WAIT_STATE_CONTROL: dir_rdata_out = wait_state_control;
      `SFRMD_MASTER_CLOCK_CONTROL: dir_rdata_out = master_clock_control;
      `SFRMD_USER_PORT_DATA_LOW: dir_rdata_out = user_port_data_low;
      `SFRMD_USER_PORT_DIRECTION_LOW: dir_rdata_out = user_port_direction_low;
      `SFRMD_POINTER_SELECT: dir_rdata_out = pointer_select;
      `SFRMD_FLASH_ERASE: dir_rdata_out = flash_erase;
      `SFRMD_SERIAL0_CONTROL: dir_rdata_out = serial0_control;
      `SFRMD_SERIAL0_BUFFER: dir_rdata_out = serial0_buffer;
      `SFRMD_INTERRUPT_ENABLE_2: dir_rdata_out = interrupt_enable_2;
      `SFRMD_SERIAL1_CONTROL: dir_rdata_out = serial1_control;
      `SFRMD_SERIAL1_BUFFER: dir_rdata_out = serial1_buffer;
      `SFRMD_SERIAL1_RELOAD_LOW: dir_rdata_out = serial1_reload_low;
      `SFRMD_USER_PORT_DATA_HIGH: dir_rdata_out = user_port_data_high;
      `SFRMD_USER_PORT_DIRECTION_HIGH: dir_rdata_out = user_port_direction_high;
      `SFRMD_INTERRUPT_ENABLE_0: dir_rdata_out = interrupt_enable_0;
      `SFRMD_INTERRUPT_PRIORITY_0: dir_rdata_out = interrupt_priority_0;
      `SFRMD_SERIAL0_RELOAD_LOW: dir_rdata_out = serial0_reload_low;
      `SFRMD_FLASH_CONTROL: dir_rdata_out = flash_control;
      `SFRMD_FLASH_PAGE_ADDRESS: dir_rdata_out = flash_page_address;
      `SFRMD_INTERRUPT_ENABLE_1: dir_rdata_out = interrupt_enable_1;
      `SFRMD_INTERRUPT_PRIORITY_1: dir_rdata_out = interrupt_priority_1;
      `SFRMD_SERIAL0_RELOAD_HIGH: dir_rdata_out = serial0_reload_high;
      `SFRMD_SERIAL1_RELOAD_HIGH: dir_rdata_out = serial1_reload_high;
      `SFRMD_INTERRUPT_REQUEST_CONTROL: dir_rdata_out = interrupt_request_control;
      `SFRMD_TIMER2_CONTROL: dir_rdata_out = timer2_control;
      `SFRMD_PROGRAM_STATUS_WORD: dir_rdata_out = program_status_word;
      `SFRMD_KEYPAD_COLUMN: dir_rdata_out = keypad_column;
      `SFRMD_KEYPAD_ROW: dir_rdata_out = keypad_row;
      `SFRMD_KEYPAD_SCAN_TIME: dir_rdata_out = keypad_scan_time;
      `SFRMD_KEYPAD_CONTROL_STATUS: dir_rdata_out = keypad_control_status;
      `SFRMD_KEYPAD_SIZE: dir_rdata_out = keypad_size;
      `SFRMD_KEYPAD_ORDER_LOW: dir_rdata_out = keypad_order_low;
      `SFRMD_KEYPAD_ORDER_HIGH: dir_rdata_out = keypad_order_high;
      `SFRMD_BAUD_RATE_CONTROL: dir_rdata_out = baud_rate_control;
      `SFRMD_ACCUMULATOR: dir_rdata_out = accumulator;
      default: dir_rdata_out = `SFRMD_HOLE_READ;
    endcase
  end

  // peripheral window decode; its registers live in other blocks
  always @* begin
    xdata_sfr_sel_out = (xdata_addr_in >= `SFRMD_XSFR_BASE);
    xdata_rdata_out = `SFRMD_XSFR_READ;
  end

endmodule // sfrmd_decoder

// ---- test/sfrmd_checker_assertions.sv ----
/*
  Checker for the register bank: decode, write, mask and reset relations.
  Assumes a bind onto sfrmd_decoder, seeing its ports only.
*/
`timescale 1ns/1ps
module sfrmd_checker (
  // clock and reset
  input wire ref_clk_in, input wire reset_in,
  // direct space
  input wire [7:0] dir_addr_in, input wire dir_wr_in, input wire [7:0] dir_wdata_in,
  input wire [7:0] dir_rdata_out, input wire dir_sfr_sel_out, input wire dir_hit_out,
  // external window and register image
  input wire [15:0] xdata_addr_in, input wire xdata_sfr_sel_out,
  input wire [7:0] xdata_rdata_out, input wire [1023:0] reg_image_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  // decode holds in every cycle, read data follows the address at once
  property p_dir_sel; dir_sfr_sel_out == dir_addr_in[7]; endproperty
  a_dir_sel: assert property (p_dir_sel) else $error("direct select wrong");
  property p_ram_miss; !dir_addr_in[7] |-> !dir_hit_out; endproperty
  a_ram_miss: assert property (p_ram_miss) else $error("ram address hit");
  property p_x_sel; xdata_sfr_sel_out == (xdata_addr_in >= 16'hFC00); endproperty
  a_x_sel: assert property (p_x_sel) else $error("window select wrong");
  property p_rd_now; dir_hit_out |-> dir_rdata_out == reg_image_out[{dir_addr_in[6:0], 3'h0} +: 8];
  endproperty
  a_rd_now: assert property (p_rd_now) else $error("read data not current");
  // writes land in one edge; a missed hole decode would corrupt the image
  property p_sp_wr; dir_wr_in && dir_addr_in == 8'h81 |=> reg_image_out[15:8] == $past(dir_wdata_in);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("write not taken");
  property p_hole_wr; dir_wr_in && !dir_hit_out |=> $stable(reg_image_out); endproperty
  a_hole_wr: assert property (p_hole_wr) else $error("hole write changed state");
  property p_idle; !dir_wr_in |=> $stable(reg_image_out); endproperty
  a_idle: assert property (p_idle) else $error("state changed without write");
  property p_baud; reg_image_out[710:704] == 7'h00; endproperty
  a_baud: assert property (p_baud) else $error("baud unused bits set");
  property p_rst; $fell(reset_in) |-> reg_image_out[15:8] == 8'h07 &&
    reg_image_out[127:120] == 8'h0A && reg_image_out[343:336] == 8'hD9; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  c_sp_wr: cover property (dir_wr_in && dir_addr_in == 8'h81);
  c_hole: cover property (dir_wr_in && !dir_hit_out && dir_addr_in[7]);
  c_x_sel: cover property (xdata_sfr_sel_out);
endmodule // sfrmd_checker
bind sfrmd_decoder sfrmd_checker u_chk (.ref_clk_in, .reset_in, .dir_addr_in, .dir_wr_in,
  .dir_wdata_in, .dir_rdata_out, .dir_sfr_sel_out, .dir_hit_out, .xdata_addr_in,
  .xdata_sfr_sel_out, .xdata_rdata_out, .reg_image_out);

// ---- test/sfrmd_core_model.sv ----
/*
  Core side model: direct space writes and reads, external address.
  Assumes the bench clock; signals change 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module sfrmd_core_model (
  // clock and read data
  input wire ref_clk_in,
  input wire [7:0] dir_rdata_in,
  // bus towards the bank
  output reg [7:0] dir_addr_out = 8'h00,
  output reg dir_wr_out = 1'b0,
  output reg [7:0] dir_wdata_out = 8'h00,
  output reg [15:0] xdata_addr_out = 16'h0000
);
  ////////////////////////////////////////////////////////////////
  // one write a call; data inverted after release so stale data never matches
  task wr(input [7:0] a, input [7:0] d); // only what the bench commands
    begin
      @(posedge ref_clk_in);
      #1 dir_addr_out = a;
      dir_wdata_out = d;
      dir_wr_out = 1'b1;
      @(posedge ref_clk_in);
      #1 dir_wr_out = 1'b0;
      dir_wdata_out = ~d;
    end
  endtask
  // read data is taken at the edge after the address settles
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge ref_clk_in);
      #1 dir_addr_out = a;
      @(posedge ref_clk_in);
      d = dir_rdata_in;
    end
  endtask
endmodule // sfrmd_core_model

// ---- test/tb_sfr_map_decoder.sv ----
/*
  Bench for the register bank: reset values, write back, mask, holes, window.
  Assumes the core model beside it and the checker bound to the bank.
*/
`timescale 1ns/1ps
module tb_sfr_map_decoder;
  localparam [223:0] RV = {16'h8107, 16'h8E01, 16'h8F0A, 16'h90FF, 16'h91FF, 16'hA101,
    16'hAAD9, 16'hBA03, 16'hBB03, 16'hD11F, 16'hD23F, 16'hD800, 16'hE000, 16'h8200};
  localparam [63:0] XA = {16'h0000, 16'hFFFF, 16'hFC00, 16'hFBFF};
  reg ref_clk_in = 1'b0;
  reg reset_in = 1'b1;
  wire [7:0] dir_addr_in, dir_wdata_in, dir_rdata_out, xdata_rdata_out;
  wire dir_wr_in, dir_sfr_sel_out, dir_hit_out, xdata_sfr_sel_out;
  wire [15:0] xdata_addr_in;
  wire [1023:0] reg_image_out;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer i;
  reg [7:0] v;
  always #12.5 ref_clk_in = ~ref_clk_in;
  sfrmd_decoder dut (.ref_clk_in, .reset_in, .dir_addr_in, .dir_wr_in, .dir_wdata_in,
    .dir_rdata_out, .dir_sfr_sel_out, .dir_hit_out, .xdata_addr_in, .xdata_sfr_sel_out,
    .xdata_rdata_out, .reg_image_out);
  sfrmd_core_model u_core (.ref_clk_in, .dir_rdata_in(dir_rdata_out), .dir_addr_out(dir_addr_in),
    .dir_wr_out(dir_wr_in), .dir_wdata_out(dir_wdata_in), .xdata_addr_out(xdata_addr_in));
  ////////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // every listed register reads its initial value
  task t_reset;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        u_core.rd(RV[16*i+8 +: 8], v);
        check(v, RV[16*i +: 8]);
        check({6'h00, dir_sfr_sel_out, dir_hit_out}, 8'h03);
      end
      $display("test reset values done");
    end
  endtask
  // inverted initial values written and read back; baud keeps its top bit only
  task t_rw;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        u_core.wr(RV[16*i+8 +: 8], ~RV[16*i +: 8]);
        u_core.rd(RV[16*i+8 +: 8], v);
        check(v, RV[16*i+8 +: 8] == 8'hD8 ? 8'h80 : ~RV[16*i +: 8]);
      end
      $display("test write back done");
    end
  endtask
  // writes to a hole and to plain ram leave the bank alone
  task t_hole;
    begin
      u_core.wr(8'h81, 8'h5A);
      u_core.wr(8'h93, 8'hA5);
      check({7'h00, dir_hit_out}, 8'h00);
      check(reg_image_out[159:152], 8'h00);
      u_core.wr(8'h01, 8'hA5);
      check({6'h00, dir_sfr_sel_out, dir_hit_out}, 8'h00);
      u_core.rd(8'h81, v);
      check(v, 8'h5A);
      u_core.rd(8'h93, v);
      check(v, 8'h00);
      $display("test holes done");
    end
  endtask
  // window edges either side of its base and at the top
  task t_x;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge ref_clk_in);
        #1 u_core.xdata_addr_out = XA[16*i +: 16];
        #1 check({7'h00, xdata_sfr_sel_out}, (i == 1 || i == 2) ? 8'h01 : 8'h00);
        check(xdata_rdata_out, 8'h00);
      end
      $display("test window done");
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    #1 reset_in = 1'b0;
    t_reset;
    t_rw;
    t_hole;
    t_x;
    @(posedge ref_clk_in);
    #1 reset_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 reset_in = 1'b0;
    t_reset;
    results;
  end
  // whole run is about 135 cycles; this cuts a hang short
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    results;
  end
endmodule // tb_sfr_map_decoder
